// ===== ccs_clock_select.sv
// Processor clock mode select: captures the configuration latch and builds the processor clock.
// Assumes oscillator, long reset and port pins are asynchronous to core_clk at 125 MHz,
// and that the oscillator is well below a quarter of core_clk so every phase is seen.
//
// Overview of operation
// RL1 - Clock mode comes from select field, bits 7 to 5 of the configuration latch.
// RL2 - Long hardware reset loads the latch from the upper port byte levels.
// RL3 - Select top bit one: processor clock is the oscillator divided by two.
// RL4 - Select top bit zero: processor clock follows the oscillator at the same rate.
// RL5 - Both processor clock edges are marked; edge-to-edge time is the half period.
// RL6 - Divided mode: each high and low phase lasts one oscillator period.
// RL7 - Direct mode: phases follow oscillator duty; two phases span one oscillator period.
// RL8 - Divider toggles on rising oscillator edges; mode stays fixed between long resets. Here a plain reset also clears the latch to direct mode.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps

module ccs_clock_select (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rstn,
	// Oscillator, long hardware reset and multiplexed port pins
	input  wire logic        osc_in,
	input  wire logic        long_reset_n,
	input  wire logic [7:0]  port_upper_byte,
	// Processor clock, its edge marks and the clock mode
	output logic             processor_clock,
	output logic             cpu_edge,
	output logic             cpu_rise,
	output logic             clock_mode,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr
);

	typedef struct packed {
		logic [7:0]  cfg_latch;
		logic        ctrl_run;
		logic        osc_d;
		logic        cpu_clk;
		logic        edge_p;
		logic        rise_p;
		logic        loading;
		logic [15:0] half_cnt;
		logic [15:0] half_len;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} ccs_st_t;

	localparam ccs_st_t ST_RST = '{
		cfg_latch: ccs_pkg::CFG_LATCH_RST,
		ctrl_run:  ccs_pkg::CTRL_RUN_RST,
		osc_d:     1'b0,
		cpu_clk:   1'b0,
		edge_p:    1'b0,
		rise_p:    1'b0,
		loading:   1'b0,
		half_cnt:  ccs_pkg::HALF_LEN_RST,
		half_len:  ccs_pkg::HALF_LEN_RST,
		pready:    1'b0,
		prdata:    32'h0000_0000,
		pslverr:   1'b0
	};

	ccs_st_t   st_ff;
	ccs_st_t   nxt_st;
	logic [9:0] pins_raw;
	logic [9:0] pins_lvl;
	logic [7:0] port_lvl;
	logic       osc_lvl;
	logic       long_rst_lvl_n;
	logic       osc_rise;
	logic       cpu_next;
	ccs_pkg::ccs_mode_t mode;
	logic       apb_access;
	logic       apb_mapped;
	logic [31:0] rd_word;

	// All pins share one synchroniser so they see the same latency. The long reset
	// enters inverted, so the cleared synchroniser reads as no long reset and a plain
	// reset does not show a false load window after release.
	assign pins_raw = {~long_reset_n, osc_in, port_upper_byte};

	ccs_pin_sync #(
		.W (10)
	) u_pin_sync (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.pin_in    (pins_raw),
		.level_out (pins_lvl)
	);

	assign port_lvl       = pins_lvl[7:0];
	assign osc_lvl        = pins_lvl[8];
	assign long_rst_lvl_n = ~pins_lvl[9];

	always_comb
	begin
		nxt_st = st_ff;

		// Only the top bit of the select field decides; the lower two are don't care.
		mode = st_ff.cfg_latch[ccs_pkg::MODE_BIT] ? ccs_pkg::CCS_PRESCALE
			: ccs_pkg::CCS_DIRECT; // RL1

		// The latch keeps following the port while long reset is held, so the
		// value at release is what stays. Only a plain reset also writes it, clearing it. 
		nxt_st.loading = !long_rst_lvl_n;
		if (!long_rst_lvl_n)
			nxt_st.cfg_latch = port_lvl; // RL2 RL8

		nxt_st.osc_d = osc_lvl;
		osc_rise     = osc_lvl && !st_ff.osc_d;

		case (mode)
			ccs_pkg::CCS_PRESCALE:
				cpu_next = osc_rise ? !st_ff.cpu_clk : st_ff.cpu_clk; // RL3 RL6 RL8
			ccs_pkg::CCS_DIRECT:
				cpu_next = osc_lvl; // RL4 RL7
			default:
				cpu_next = st_ff.cpu_clk;
		endcase

		// A stopped clock parks low so a divided-mode restart begins with a full high phase.
		if (!st_ff.ctrl_run)
			cpu_next = 1'b0;
		nxt_st.cpu_clk = cpu_next;

		// Both edges are marked; the half period is measured edge to edge.
		nxt_st.edge_p = cpu_next != st_ff.cpu_clk; // RL5
		nxt_st.rise_p = cpu_next && !st_ff.cpu_clk;
		if (cpu_next != st_ff.cpu_clk)
		begin
			nxt_st.half_len = st_ff.half_cnt + 16'h0001; // RL5
			nxt_st.half_cnt = 16'h0000;
		end
		else if (st_ff.half_cnt != ccs_pkg::HALF_CNT_MAX)
		begin
			nxt_st.half_cnt = st_ff.half_cnt + 16'h0001;
		end

		// APB: one wait state, pready high for one cycle of the access phase.
		apb_access = psel && penable;
		apb_mapped = (paddr == ccs_pkg::OFS_CFG_LATCH) || (paddr == ccs_pkg::OFS_STATUS)
			|| (paddr == ccs_pkg::OFS_HALF_LEN) || (paddr == ccs_pkg::OFS_CTRL);
		rd_word = 32'h0000_0000;
		case (paddr)
			ccs_pkg::OFS_CFG_LATCH:
				rd_word[7:0] = st_ff.cfg_latch;
			ccs_pkg::OFS_STATUS:
			begin
				rd_word[ccs_pkg::STAT_MODE]    = st_ff.cfg_latch[ccs_pkg::MODE_BIT];
				rd_word[ccs_pkg::STAT_CLK]     = st_ff.cpu_clk;
				rd_word[ccs_pkg::STAT_LOADING] = st_ff.loading;
			end
			ccs_pkg::OFS_HALF_LEN:
				rd_word[15:0] = st_ff.half_len;
			ccs_pkg::OFS_CTRL:
				rd_word[ccs_pkg::CTRL_RUN] = st_ff.ctrl_run;
			default:
				rd_word = 32'h0000_0000;
		endcase

		nxt_st.pready  = apb_access && !st_ff.pready;
		nxt_st.pslverr = apb_access && !st_ff.pready && !apb_mapped;
		if (apb_access && !st_ff.pready)
			nxt_st.prdata = pwrite ? 32'h0000_0000 : rd_word;

		// A write takes effect only on the edge where pready is seen high.
		if (apb_access && st_ff.pready && pwrite && (paddr == ccs_pkg::OFS_CTRL))
			nxt_st.ctrl_run = pwdata[ccs_pkg::CTRL_RUN];
	end

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
			st_ff <= ST_RST;
		else
			st_ff <= nxt_st;
	end

	assign processor_clock = st_ff.cpu_clk;
	assign cpu_edge        = st_ff.edge_p;
	assign cpu_rise        = st_ff.rise_p;
	assign clock_mode      = st_ff.cfg_latch[ccs_pkg::MODE_BIT];
	assign pready          = st_ff.pready;
	assign prdata          = st_ff.prdata;
	assign pslverr         = st_ff.pslverr;

	latch_load_a: assert property (@(posedge core_clk) disable iff (!rstn) // RL2
		!long_rst_lvl_n |=> (st_ff.cfg_latch == $past(port_lvl)))
		else $error("Configuration latch did not load the port levels.");

	mode_fixed_a: assert property (@(posedge core_clk) disable iff (!rstn) // RL8
		long_rst_lvl_n |=> $stable(st_ff.cfg_latch))
		else $error("Configuration latch changed outside long reset.");

	mode_bit_a: assert property (@(posedge core_clk) disable iff (!rstn) // RL1
		(!clock_mode && st_ff.ctrl_run && !osc_lvl && st_ff.osc_d)
		|=> !processor_clock)
		else $error("Direct mode did not follow a falling oscillator edge.");

	prescale_toggle_a: assert property (@(posedge core_clk) disable iff (!rstn) // RL3
		(st_ff.cfg_latch[7] && st_ff.ctrl_run && osc_lvl && !st_ff.osc_d)
		|=> (st_ff.cpu_clk != $past(st_ff.cpu_clk)))
		else $error("Divider did not toggle on a rising oscillator edge.");

	prescale_hold_a: assert property (@(posedge core_clk) disable iff (!rstn) // RL6
		(st_ff.cfg_latch[7] && st_ff.ctrl_run && !(osc_lvl && !st_ff.osc_d))
		|=> $stable(st_ff.cpu_clk))
		else $error("Divided clock changed without a rising oscillator edge.");

	direct_follow_a: assert property (@(posedge core_clk) disable iff (!rstn) // RL4 RL7
		(!st_ff.cfg_latch[7] && st_ff.ctrl_run) |=> (st_ff.cpu_clk == $past(osc_lvl)))
		else $error("Direct clock does not follow the oscillator.");

	edge_mark_a: assert property (@(posedge core_clk) disable iff (!rstn) // RL5
		$changed(st_ff.cpu_clk) |-> (st_ff.edge_p && (st_ff.rise_p == st_ff.cpu_clk)))
		else $error("Processor clock edge was not marked.");

	half_len_a: assert property (@(posedge core_clk) disable iff (!rstn) // RL5
		$changed(st_ff.cpu_clk) |-> (st_ff.half_len == $past(st_ff.half_cnt) + 16'h0001))
		else $error("Half period length was not captured.");

	apb_pulse_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(psel && !penable) ##1 (psel && penable) |=> pready ##1 !pready)
		else $error("APB answer is not a single cycle after one wait.");

	// Edge marks and the stopped clock.
	edge_only_a: assert property (@(posedge core_clk) disable iff (!rstn) // RL5
		st_ff.edge_p
		|-> $changed(st_ff.cpu_clk))
		else $error("Edge mark without a processor clock change.");

	rise_only_a: assert property (@(posedge core_clk) disable iff (!rstn) // RL5
		st_ff.rise_p
		|-> (st_ff.edge_p && st_ff.cpu_clk))
		else $error("Rise mark without a rising processor clock.");

	stop_low_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!st_ff.ctrl_run
		|=> !st_ff.cpu_clk)
		else $error("Stopped processor clock is not parked low.");

	stop_quiet_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(!st_ff.ctrl_run && !st_ff.cpu_clk)
		|=> !st_ff.edge_p)
		else $error("Stopped processor clock still marks edges.");

	// Latch loading, its status flag and the status mode bit.
	load_flag_a: assert property (@(posedge core_clk) disable iff (!rstn) // RL2
		!long_rst_lvl_n
		|=> st_ff.loading)
		else $error("Long reset is not shown as loading.");

	no_load_a: assert property (@(posedge core_clk) disable iff (!rstn) // RL8
		long_rst_lvl_n
		|=> !st_ff.loading)
		else $error("Loading is shown outside long reset.");

	status_mode_a: assert property (@(posedge core_clk) disable iff (!rstn) // RL1
		(psel && penable && !pready && !pwrite && (paddr == ccs_pkg::OFS_STATUS))
		|=> (prdata[ccs_pkg::STAT_MODE] == $past(clock_mode)))
		else $error("Status does not show the clock mode.");

	// Register bus answers.
	err_ready_a: assert property (@(posedge core_clk) disable iff (!rstn)
		pslverr
		|-> pready)
		else $error("Slave error outside an answer cycle.");

	err_zero_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(pslverr && !pwrite)
		|-> (prdata == 32'h0000_0000))
		else $error("Unmapped read did not return zero.");

	ready_access_a: assert property (@(posedge core_clk) disable iff (!rstn)
		pready
		|-> $past(psel && penable))
		else $error("Answer without an access phase.");

	ready_idle_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!psel
		|=> !pready)
		else $error("Answer without a selected slave.");

	prdata_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!(psel && penable)
		|=> $stable(prdata))
		else $error("Read data changed outside an access.");

	ctrl_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(psel && penable && pready && pwrite && (paddr == ccs_pkg::OFS_CTRL))
		|=> (st_ff.ctrl_run == $past(pwdata[ccs_pkg::CTRL_RUN])))
		else $error("Run bit did not take the written value.");

	ctrl_keep_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!(psel && penable && pready && pwrite)
		|=> $stable(st_ff.ctrl_run))
		else $error("Run bit changed without a write.");

endmodule

// ===== ccs_osc_model.sv
// Oscillator partner: a clock source with set high and low phase lengths.
// Assumes lengths in core_clk cycles, longer than the pin filter delay.
`timescale 1ns/100ps

module ccs_osc_model (
	// Clock and control
	input  wire logic       core_clk,
	input  wire logic       enable,
	input  wire logic [7:0] high_len,
	input  wire logic [7:0] low_len,
	// Oscillator pin
	output logic            osc_in
);
	logic [7:0] cnt;

	initial
	begin
		osc_in = 1'b0;
		cnt = 8'h00;
	end

	// A stopped source rests low, so no stray edge reaches the divider.
	always @(posedge core_clk)
	begin
		if (!enable)
		begin
			osc_in <= 1'b0;
			cnt <= 8'h00;
		end
		else if (cnt + 8'h01 >= (osc_in ? high_len : low_len))
		begin
			osc_in <= ~osc_in;
			cnt <= 8'h00;
		end
		else
			cnt <= cnt + 8'h01;
	end
endmodule

// ===== ccs_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous pin levels; output changes only when stages two and three agree.
`timescale 1ns/100ps

module ccs_pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rstn,
	// Pins and filtered levels
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} ccs_sync_st_t;

	ccs_sync_st_t st_ff;
	ccs_sync_st_t nxt_st;
	logic [W-1:0] agree;

	// The first stage feeds only the second; the filter looks at stages two and three.
	always_comb
	begin
		agree     = ~(st_ff.s2 ^ st_ff.s3);
		nxt_st    = st_ff;
		nxt_st.s1 = pin_in;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		nxt_st.q  = (st_ff.s3 & agree) | (st_ff.q & ~agree);
	end

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign level_out = st_ff.q;

	sync_agree_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(st_ff.s2 == st_ff.s3) |=> (st_ff.q == $past(st_ff.s3)))
		else $error("Filtered level did not take the agreed value.");

endmodule

// ===== ccs_pkg.sv
// Constants shared by the processor clock mode select block.
// Assumes one 125 MHz core clock and an APB master with 32-bit data.
package ccs_pkg;

	// Register byte offsets on the APB slave.
	localparam logic [7:0] OFS_CFG_LATCH = 8'h00;
	localparam logic [7:0] OFS_STATUS    = 8'h04;
	localparam logic [7:0] OFS_HALF_LEN  = 8'h08;
	localparam logic [7:0] OFS_CTRL      = 8'h0c;

	// Fields of the reset configuration latch.
	localparam int CLK_SEL_MSB = 7;
	localparam int CLK_SEL_LSB = 5;
	localparam int MODE_BIT    = 7;

	// Fields of the status register.
	localparam int STAT_MODE   = 0;
	localparam int STAT_CLK    = 1;
	localparam int STAT_LOADING = 2;

	// Fields of the control register.
	localparam int CTRL_RUN    = 0;

	// Values after reset, and the saturation limit of the half period counter.
	localparam logic [7:0]  CFG_LATCH_RST = 8'h00;
	localparam logic        CTRL_RUN_RST  = 1'b1;
	localparam logic [15:0] HALF_LEN_RST  = 16'h0000;
	localparam logic [15:0] HALF_CNT_MAX  = 16'hffff;

	// Pin synchroniser depth.
	localparam int SYNC_STAGES = 3;

	// Clock generation modes, selected by the top bit of the select field.
	typedef enum logic {
		CCS_DIRECT,
		CCS_PRESCALE
	} ccs_mode_t;

endpackage

// ===== testbench.sv
// Self-checking bench for the processor clock mode select block.
// Assumes the oscillator model drives osc_in and the bench acts as APB master.
`timescale 1ns/100ps

module testbench;
	logic        core_clk, rstn, osc_en, long_reset_n, osc_in;
	logic        psel, penable, pwrite, pready, pslverr;
	logic        processor_clock, cpu_edge, cpu_rise, clock_mode;
	logic [7:0]  paddr, port_upper_byte;
	logic [31:0] pwdata, prdata, rd;
	logic        er;
	int          failures, checks, cycles, t0, t1, t2;

	ccs_osc_model osc (.core_clk, .enable(osc_en), .high_len(8'h06), .low_len(8'h0a), .osc_in);
	ccs_clock_select dut (.core_clk, .rstn, .osc_in, .long_reset_n, .port_upper_byte,
		.processor_clock, .cpu_edge, .cpu_rise, .clock_mode, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pready, .prdata, .pslverr);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		if (failures == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// The request is held until pready is seen high at an edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic gap(input bit rise_only, output int t);
		t = 0;
		do
		begin
			@(posedge core_clk);
			t++;
		end
		while ((rise_only ? cpu_rise : cpu_edge) !== 1'b1 && t < 300);
	endtask

	// Pins move after release, so a latch that keeps following them shows up.
	task automatic boot(input logic [7:0] pins);
		@(posedge core_clk);
		port_upper_byte <= pins;
		long_reset_n <= 1'b0;
		repeat (10) @(posedge core_clk);
		long_reset_n <= 1'b1;
		repeat (6) @(posedge core_clk);
		port_upper_byte <= ~pins;
		repeat (6) @(posedge core_clk);
		apb(1'b0, ccs_pkg::OFS_CFG_LATCH, 32'h0);
		check(rd, {24'h0, pins});
		check(clock_mode, pins[7]);
		gap(1'b1, t0);
		gap(1'b0, t1);
		gap(1'b0, t2);
	endtask

	task automatic t_regs;
		apb(1'b0, ccs_pkg::OFS_CFG_LATCH, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, ccs_pkg::OFS_CFG_LATCH, 32'hffffffff);
		apb(1'b0, ccs_pkg::OFS_CFG_LATCH, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		check(er, 1'b1);
		apb(1'b0, ccs_pkg::OFS_CTRL, 32'h0);
		check(rd, 32'h1);
	endtask

	task automatic t_prescale;
		boot(8'h9f);
		check(t1, 16);
		check(t2, 16);
		apb(1'b0, ccs_pkg::OFS_STATUS, 32'h0);
		check(rd[0], 1'b1);
		apb(1'b0, ccs_pkg::OFS_HALF_LEN, 32'h0);
		check(rd, 32'h10);
	endtask

	task automatic t_direct;
		boot(8'h60);
		check(t1, 6);
		check(t2, 10);
		check(t1 + t2, 16);
	endtask

	task automatic t_stop;
		apb(1'b1, ccs_pkg::OFS_CTRL, 32'h0);
		repeat (4) @(posedge core_clk);
		t0 = 0;
		repeat (40)
		begin
			@(posedge core_clk);
			t0 += int'(cpu_edge === 1'b1);
		end
		check(t0, 0);
		check(processor_clock, 1'b0);
		apb(1'b1, ccs_pkg::OFS_CTRL, 32'h1);
	endtask

	// A plain reset clears the latch and must not look like a long reset.
	task automatic t_rst;
		@(posedge core_clk);
		rstn <= 1'b0;
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		apb(1'b0, ccs_pkg::OFS_STATUS, 32'h0);
		check(rd[2], 1'b0);
		apb(1'b0, ccs_pkg::OFS_CFG_LATCH, 32'h0);
		check(rd, 32'h0);
	endtask

	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			print_verdict();
		end
	end

	initial
	begin
		{rstn, osc_en, psel, penable, pwrite, paddr, pwdata} = '0;
		long_reset_n = 1'b1;
		port_upper_byte = 8'h00;
		{failures, checks, cycles} = '0;
		repeat (16) @(posedge core_clk);
		rstn <= 1'b1;
		osc_en <= 1'b1;
		t_regs();
		t_prescale();
		t_stop();
		t_direct();
		t_rst();
		print_verdict();
	end
endmodule
